// ===== sfw_pkg.sv
// Constants, types and carriers shared by the register write-protect block.
// Assumes a 20 MHz system clock and a serial link in clock mode 0 or 3.
package sfw_pkg;

    // ==========================================================
    // Opcodes
    localparam logic [7:0] OP_BANK_READ    = 8'h16;
    localparam logic [7:0] OP_BANK_WRITE   = 8'h17;
    localparam logic [7:0] OP_LEGACY_BANK  = 8'hb9;
    localparam logic [7:0] OP_WRITE_REGS   = 8'h01;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DIS    = 8'h04;
    localparam logic [7:0] OP_READ_STATUS  = 8'h05;
    localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;
    localparam logic [7:0] OP_PAGE_PROG    = 8'h02;
    localparam logic [7:0] OP_QUAD_PROG    = 8'h32;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'hd8;
    localparam logic [7:0] OP_BULK_ERASE   = 8'hc7;

    // ==========================================================
    // Register fields and reset values
    localparam int SR_WIP   = 0;
    localparam int SR_WEL   = 1;
    localparam int SR_BP_LO = 2;
    localparam int SR_BP_HI = 4;
    localparam int SR_E_ERR = 5;
    localparam int SR_P_ERR = 6;
    localparam int SR_STATUS_WRITE_DISABLE  = 7;
    localparam int CR_QUAD  = 1;
    localparam int BAR_EXT  = 7;
    localparam logic [7:0] SR1_RESET = 8'h00;
    localparam logic [7:0] CR_RESET  = 8'h00;
    localparam logic [7:0] BAR_RESET = 8'h00;
    localparam int SECT_HI = 25;
    localparam int SECT_LO = 20;

    // ==========================================================
    // Frame bit counts
    localparam logic [5:0] BITS_OPCODE = 6'h08;
    localparam logic [5:0] BITS_BYTE1  = 6'h10;
    localparam logic [5:0] BITS_BYTE2  = 6'h18;
    localparam logic [5:0] BITS_ADDR3  = 6'h20;
    localparam logic [5:0] BITS_ADDR4  = 6'h28;
    localparam logic [5:0] BITS_MAX    = 6'h3f;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS     = 50;
    localparam int REG_UPDATE_NS     = 2000;
    localparam int REG_UPDATE_CYCLES = (REG_UPDATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_UPDATE = 2'b01,
        ST_FINISH = 2'b11
    } sfw_upd_state_t;

    typedef enum logic [1:0] {
        OPK_PAGE   = 2'b00,
        OPK_QUAD   = 2'b01,
        OPK_SECTOR = 2'b10,
        OPK_BULK   = 2'b11
    } sfw_op_kind_t;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [5:0]  bits;
        logic [7:0]  data1;
        logic [7:0]  data2;
        logic [31:0] addr;
        logic        addr4;
    } sfw_frame_t;

    typedef struct packed {
        logic [7:0] bar;
        logic [7:0] sr1;
    } sfw_view_t;

endpackage : sfw_pkg

// ===== sfw_sync.sv
// Two-flop level synchroniser for a bus of independent or quasi-static bits.
// Assumes multi-bit inputs only change while the reader ignores them.
`timescale 1ns/1ps
module sfw_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // ==========================================================
    // Synchroniser stages
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule : sfw_sync

// ===== sfw_prot_check.sv
// Block-protect area check: the top 2^(level-1) of 64 sectors are read-only.
// Assumes a 64-sector array; level 7 covers the whole array.
`timescale 1ns/1ps
module sfw_prot_check (
    input  wire logic [2:0] bp,
    input  wire logic [5:0] sector,
    input  wire logic       bulk,
    output logic            protected_area
);
    logic [6:0] size;
    logic [6:0] first;

    // ==========================================================
    // Protected range compare
    always_comb
    begin
        size  = 7'h01 << (bp - 3'h1);
        first = 7'h40 - size;
        if (bp == 3'h0)
            protected_area = 1'b0;
        else if (bulk)
            protected_area = 1'b1;
        else
            protected_area = ({1'b0, sector} >= first);
    end

endmodule : sfw_prot_check

// ===== sfw_core.sv
// Command handling for the bank register, write-registers and write protection.
// Assumes sck toggles only while cs_n is low, in clock mode 0 or 3.
`timescale 1ns/1ps
module sfw_core (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic                 sck,
    input  wire logic                 cs_n,
    input  wire logic                 si,
    input  wire logic                 wp_n,
    input  wire logic                 reg_update_fail,
    output logic                      so,
    output logic                      so_oe,
    output logic                      write_in_progress,
    output logic [7:0]                bank_addr,
    output logic                      array_op_valid,
    output sfw_pkg::sfw_op_kind_t     array_op_kind,
    output logic [31:0]               array_op_addr
);
    import sfw_pkg::*;

    // ==========================================================
    // Link domain
    logic       frame_idle;
    logic       armed;
    logic [5:0] cnt;
    logic [5:0] next_cnt;
    logic [31:0] sh;
    logic [31:0] next_sh;
    logic       frame_tgl;
    sfw_frame_t frm;
    sfw_view_t  view;
    sfw_view_t  view_link;
    logic [7:0] out_sh;
    logic [7:0] src;
    logic       is_read;

    assign frame_idle = cs_n | ~resetn;

    // The frame start flag is preset while chip select is high.
    always_ff @(posedge sck or posedge frame_idle)
    begin
        if (frame_idle)
            armed <= 1'b1;
        else
            armed <= 1'b0;
    end

    always_comb
    begin
        next_sh = {sh[30:0], si};
        if (armed)
            next_cnt = 6'h01;
        else if (cnt != BITS_MAX)
            next_cnt = cnt + 6'h01;
        else
            next_cnt = cnt;
    end

    always_ff @(posedge sck or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt       <= 6'h00;
            sh        <= 32'h0000_0000;
            frame_tgl <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            sh  <= next_sh;
            if (armed)
                frame_tgl <= ~frame_tgl;
        end
    end

    // Fields are captured at their exact bit counts and then held for the clk side.
    always_ff @(posedge sck or negedge resetn)
    begin
        if (!resetn)
            frm <= '0;
        else
        begin
            frm.bits <= next_cnt;
            if (next_cnt == BITS_OPCODE)
                frm.opcode <= next_sh[7:0];
            if (next_cnt == BITS_BYTE1)
                frm.data1 <= next_sh[7:0];
            if (next_cnt == BITS_BYTE2)
                frm.data2 <= next_sh[7:0];
            if (next_cnt == BITS_ADDR3 && !view_link.bar[BAR_EXT])
            begin
                frm.addr  <= {8'h00, next_sh[23:0]};
                frm.addr4 <= 1'b0;
            end
            if (next_cnt == BITS_ADDR4 && view_link.bar[BAR_EXT])
            begin
                frm.addr  <= next_sh;
                frm.addr4 <= 1'b1;
            end
        end
    end

    // Register view only changes between frames, so the bus is quasi-static.
    sfw_sync #(
        .WIDTH (16)
    ) u_view_sync (
        .clk    (sck),
        .resetn (resetn),
        .d      (view),
        .q      (view_link)
    );

    assign is_read = (frm.opcode == OP_BANK_READ) || (frm.opcode == OP_READ_STATUS);
    assign src     = (frm.opcode == OP_BANK_READ) ? view_link.bar : view_link.sr1;

    always_ff @(negedge sck or posedge frame_idle)
    begin
        if (frame_idle)
        begin
            so     <= 1'b0;
            so_oe  <= 1'b0;
            out_sh <= 8'h00;
        end
        else if (is_read && !armed && cnt >= BITS_OPCODE && cnt[2:0] == 3'h0)
        begin
            so     <= src[7];
            out_sh <= {src[6:0], 1'b0};
            so_oe  <= 1'b1;
        end
        else
        begin
            so     <= out_sh[7];
            out_sh <= {out_sh[6:0], 1'b0};
        end
    end

    // ==========================================================
    // Crossing into the system clock
    logic cs_s;
    logic tgl_s;
    logic wp_s;
    logic cs_q;
    logic tgl_seen;
    logic frame_end;
    logic frame_new;

    sfw_sync #(
        .WIDTH (3)
    ) u_link_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      ({wp_n, cs_n, frame_tgl}),
        .q      ({wp_s, cs_s, tgl_s})
    );

    assign frame_end = cs_s & ~cs_q;
    assign frame_new = frame_end & (tgl_s != tgl_seen);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cs_q     <= 1'b1;
            tgl_seen <= 1'b0;
        end
        else
        begin
            cs_q <= cs_s;
            if (frame_end)
                tgl_seen <= tgl_s;
        end
    end

    // ==========================================================
    // Registers and decode
    logic [7:0]  bar;
    logic [7:0]  cr;
    logic        status_write_disable;
    logic [2:0]  bp;
    logic        write_enable_latch;
    logic        p_err;
    logic        e_err;
    logic        bank_access;
    sfw_upd_state_t state;
    logic [15:0] timer;
    logic [7:0]  pend_sr;
    logic [7:0]  pend_cr;
    logic        pend_cr_en;
    logic [7:0]  op;
    logic        busy;
    logic        exact8;
    logic        wrr_len_ok;
    logic        locked;
    logic        do_write_enable_cmd;
    logic        do_wrdi;
    logic        do_legacy_bank_access_cmd;
    logic        do_bank_wr;
    logic        do_bank_legacy;
    logic        do_wrr;
    logic        do_clsr;
    logic        do_array;
    logic        prot;
    logic [5:0]  addr_bits;
    logic [31:0] full_addr;
    sfw_op_kind_t kind;
    logic        kind_ok;

    assign op     = frm.opcode;
    assign busy   = (state != ST_IDLE);
    assign exact8 = (frm.bits == BITS_OPCODE);
    assign wrr_len_ok = (frm.bits == BITS_BYTE1) || (frm.bits == BITS_BYTE2);
    assign locked = status_write_disable & ~wp_s & ~cr[CR_QUAD];
    assign addr_bits = frm.addr4 ? BITS_ADDR4 : BITS_ADDR3;
    assign full_addr = frm.addr4 ? frm.addr : {1'b0, bar[6:0], frm.addr[23:0]};

    sfw_prot_check u_prot (
        .bp             (bp),
        .sector         (full_addr[SECT_HI:SECT_LO]),
        .bulk           (op == OP_BULK_ERASE),
        .protected_area (prot)
    );

    always_comb
    begin
        kind    = OPK_PAGE;
        kind_ok = 1'b0;
        case (op)
            OP_PAGE_PROG:
            begin
                kind    = OPK_PAGE;
                kind_ok = frm.bits >= addr_bits + BITS_OPCODE;
            end
            OP_QUAD_PROG:
            begin
                kind    = OPK_QUAD;
                kind_ok = frm.bits >= addr_bits + BITS_OPCODE;
            end
            OP_SECTOR_ERASE:
            begin
                kind    = OPK_SECTOR;
                kind_ok = frm.bits == addr_bits;
            end
            OP_BULK_ERASE:
            begin
                kind    = OPK_BULK;
                kind_ok = exact8;
            end
            default:
            begin
                kind    = OPK_PAGE;
                kind_ok = 1'b0;
            end
        endcase
    end

    assign do_write_enable_cmd    = frame_new & (op == OP_WRITE_ENABLE) & exact8 & ~busy;
    assign do_wrdi    = frame_new & (op == OP_WRITE_DIS) & exact8 & ~busy;
    assign do_legacy_bank_access_cmd    = frame_new & (op == OP_LEGACY_BANK) & exact8;
    assign do_bank_wr = frame_new & (op == OP_BANK_WRITE) & (frm.bits >= BITS_BYTE1);
    assign do_clsr    = frame_new & (op == OP_CLEAR_STATUS) & exact8;
    assign do_bank_legacy = frame_new & (op == OP_WRITE_REGS) & bank_access & wrr_len_ok;
    assign do_wrr = frame_new & (op == OP_WRITE_REGS) & ~bank_access & wrr_len_ok
                  & write_enable_latch & ~busy & ~locked;
    assign do_array = frame_new & kind_ok & write_enable_latch & ~busy & ~prot;

    // Every frame end closes bank access; only the legacy opcode reopens it.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            bank_access <= 1'b0;
        else if (frame_end)
            bank_access <= do_legacy_bank_access_cmd;
    end

    // Bank register; the extended bit is never touched by the legacy path.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            bar <= BAR_RESET;
        else if (do_bank_wr)
            bar <= frm.data1;
        else if (do_bank_legacy)
            bar[1:0] <= frm.data1[1:0];
    end

    assign bank_addr = bar;

    // ==========================================================
    // Self-timed register update
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state      <= ST_IDLE;
            timer      <= 16'h0000;
            pend_sr    <= SR1_RESET;
            pend_cr    <= CR_RESET;
            pend_cr_en <= 1'b0;
            write_in_progress        <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (do_wrr)
                    begin
                        state      <= ST_UPDATE;
                        timer      <= 16'(REG_UPDATE_CYCLES - 1);
                        pend_sr    <= frm.data1;
                        pend_cr    <= frm.data2;
                        pend_cr_en <= (frm.bits == BITS_BYTE2);
                        write_in_progress        <= 1'b1;
                    end
                end
                ST_UPDATE:
                begin
                    if (timer == 16'h0000)
                        state <= ST_FINISH;
                    else
                        timer <= timer - 16'h0001;
                end
                ST_FINISH:
                begin
                    state <= ST_IDLE;
                    write_in_progress   <= 1'b0;
                end
                default:
                begin
                    state <= ST_IDLE;
                    write_in_progress   <= 1'b0;
                end
            endcase
        end
    end

    // Status and configuration bits; hardware sets win over same-cycle clears.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            status_write_disable  <= SR1_RESET[SR_STATUS_WRITE_DISABLE];
            bp    <= SR1_RESET[SR_BP_HI:SR_BP_LO];
            write_enable_latch   <= SR1_RESET[SR_WEL];
            p_err <= SR1_RESET[SR_P_ERR];
            e_err <= SR1_RESET[SR_E_ERR];
            cr    <= CR_RESET;
        end
        else
        begin
            if (do_clsr)
            begin
                p_err <= 1'b0;
                e_err <= 1'b0;
            end
            if (do_write_enable_cmd)
                write_enable_latch <= 1'b1;
            else if (do_wrdi || do_array)
                write_enable_latch <= 1'b0;
            if (state == ST_FINISH)
            begin
                write_enable_latch <= 1'b0;
                if (reg_update_fail)
                    p_err <= 1'b1;
                else
                begin
                    status_write_disable <= pend_sr[SR_STATUS_WRITE_DISABLE];
                    bp   <= pend_sr[SR_BP_HI:SR_BP_LO];
                    if (pend_cr_en)
                        cr <= pend_cr;
                end
            end
        end
    end

    // Snapshot for the link side is frozen while a frame is open.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            view <= '0;
        else if (cs_s)
            view <= '{bar: bar, sr1: {status_write_disable, p_err, e_err, bp, write_enable_latch, write_in_progress}};
    end

    // ==========================================================
    // Array operation launch
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            array_op_valid <= 1'b0;
            array_op_kind  <= OPK_PAGE;
            array_op_addr  <= 32'h0000_0000;
        end
        else
        begin
            array_op_valid <= do_array;
            if (do_array)
            begin
                array_op_kind <= kind;
                array_op_addr <= full_addr;
            end
        end
    end

endmodule : sfw_core

// ===== sfw_core_props.sv
// Concurrent checks on the ports of the register write-protect block.
// Assumes the package update length matches the design build.
`timescale 1ns/1ps
module sfw_core_props (
    input wire logic                  clk,
    input wire logic                  resetn,
    input wire logic                  cs_n,
    input wire logic                  so_oe,
    input wire logic                  write_in_progress,
    input wire logic [7:0]            bank_addr,
    input wire logic                  array_op_valid,
    input wire sfw_pkg::sfw_op_kind_t array_op_kind
);
    import sfw_pkg::*;
    logic [6:0] wip_cnt;

    // ==========
    // Counts the cycles of one register update.
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            wip_cnt <= 7'h00;
        else if (write_in_progress)
            wip_cnt <= wip_cnt + 7'h01;
        else
            wip_cnt <= 7'h00;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // ==========
    // Port properties.
    wip_length_a: assert property ($fell(write_in_progress) |-> wip_cnt == REG_UPDATE_CYCLES + 1)
        else $error("update length wrong");
    wip_start_a: assert property ($rose(write_in_progress) |-> cs_n && $past(cs_n, 3))
        else $error("update began inside a frame");
    wip_hold_a: assert property ($rose(write_in_progress) |-> write_in_progress [*8])
        else $error("update ended too soon");
    so_idle_a: assert property (cs_n |-> !so_oe)
        else $error("output driven while deselected");
    so_start_a: assert property ($rose(so_oe) |-> !cs_n)
        else $error("output enabled outside a frame");
    op_pulse_a: assert property (array_op_valid |=> !array_op_valid)
        else $error("array launch longer than one cycle");
    op_framed_a: assert property (array_op_valid |-> cs_n && $past(cs_n, 2))
        else $error("array launch before frame end");
    op_kind_held_a: assert property (!array_op_valid |-> $stable(array_op_kind))
        else $error("array kind moved without launch");
    bank_quiet_a: assert property ($changed(bank_addr) |-> cs_n && $stable(write_in_progress))
        else $error("bank update disturbed busy state");
endmodule : sfw_core_props

bind sfw_core sfw_core_props sfw_core_props_i (.clk(clk), .resetn(resetn), .cs_n(cs_n),
    .so_oe(so_oe), .write_in_progress(write_in_progress), .bank_addr(bank_addr), .array_op_valid(array_op_valid),
    .array_op_kind(array_op_kind));

// ===== sfw_host.sv
// Host link model: sends one frame at a time in clock mode 0.
// Assumes the bench calls xfer from a single process.
`timescale 1ns/1ps
module sfw_host (
    input  wire logic        clk,
    output logic             sck,
    output logic             cs_n,
    output logic             si,
    input  wire logic        so,
    output logic [15:0]      rd
);
    initial
    begin
        sck  = 1'b0;
        cs_n = 1'b1;
        si   = 1'b1;
        rd   = 16'h0000;
    end

    // ==========
    // Sends n bits of d and keeps the last 16 bits seen on so.
    task automatic xfer(input logic [39:0] d, input int n);
        @(negedge clk);
        cs_n = 1'b0;
        #110;
        for (int i = n - 1; i >= 0; i--)
        begin
            si = d[i];
            #3 sck = 1'b1;
            rd = {rd[14:0], so};
            #3 sck = 1'b0;
        end
        #3 cs_n = 1'b1;
        si = ~si;
        #300;
    endtask : xfer
endmodule : sfw_host

// ===== spi_flash_register_write_protect_test.sv
// Self-checking bench for the register write-protect block.
// Assumes sfw_host as far side and the bound port checker.
`timescale 1ns/1ps
module spi_flash_register_write_protect_test;
    import sfw_pkg::*;
    logic         clk;
    logic         resetn;
    logic         sck;
    logic         cs_n;
    logic         si;
    logic         wp_n;
    logic         reg_update_fail;
    logic         so;
    logic         so_oe;
    logic         write_in_progress;
    logic [7:0]   bank_addr;
    logic         array_op_valid;
    sfw_op_kind_t array_op_kind;
    logic [31:0]  array_op_addr;
    logic [15:0]  rd;
    logic [17:0]  steps [8];
    int           fails;
    int           n_checks;
    int           n_ops;
    int           cycles;

    sfw_core sfw_core_i (.clk(clk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .si(si),
        .wp_n(wp_n), .reg_update_fail(reg_update_fail), .so(so), .so_oe(so_oe), .write_in_progress(write_in_progress),
        .bank_addr(bank_addr), .array_op_valid(array_op_valid),
        .array_op_kind(array_op_kind), .array_op_addr(array_op_addr));
    sfw_host sfw_host_i (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .rd(rd));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (array_op_valid === 1'b1)
            n_ops++;
        if (cycles == 6000)
        begin
            fails++;
            final_report();
        end
    end

    // ==========
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask : check

    task automatic final_report();
        $display("Checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    task automatic write_enable_cmd();
        sfw_host_i.xfer({32'h0, OP_WRITE_ENABLE}, 8);
    endtask : write_enable_cmd

    task automatic status();
        sfw_host_i.xfer({24'h0, OP_READ_STATUS, 8'h00}, 16);
    endtask : status

    task automatic wait_idle();
        for (int i = 0; i < 100 && write_in_progress !== 1'b0; i++)
            @(posedge clk);
        @(negedge clk);
        check("wip at end", 32'h0, {31'h0, write_in_progress});
    endtask : wait_idle

    task automatic write_registers_cmd(input logic [15:0] regs, input int n, input logic exp);
        write_enable_cmd();
        sfw_host_i.xfer({16'h0, OP_WRITE_REGS, regs} >> (24 - n), n);
        check("wip after write", {31'h0, exp}, {31'h0, write_in_progress});
        wait_idle();
    endtask : write_registers_cmd

    // ==========
    task automatic t_bank();
        sfw_host_i.xfer({24'h0, OP_BANK_WRITE, 8'h81}, 16);
        check("bank write", 32'h81, {24'h0, bank_addr});
        check("wip on bank write", 32'h0, {31'h0, write_in_progress});
        sfw_host_i.xfer({16'h0, OP_BANK_READ, 16'h0000}, 24);
        check("bank read", 32'h8181, {16'h0, rd});
    endtask : t_bank

    task automatic t_legacy();
        sfw_host_i.xfer({32'h0, OP_LEGACY_BANK}, 8);
        sfw_host_i.xfer({16'h0, OP_WRITE_REGS, 16'hffff}, 24);
        check("legacy bank", 32'h83, {24'h0, bank_addr});
        check("wip on legacy", 32'h0, {31'h0, write_in_progress});
        sfw_host_i.xfer({32'h0, OP_LEGACY_BANK}, 8);
        sfw_host_i.xfer(40'h0, 0);
        write_registers_cmd(16'h0000, 24, 1'b1);
        check("bank after close", 32'h83, {24'h0, bank_addr});
    endtask : t_legacy

    task automatic t_len();
        write_registers_cmd(16'h0000, 20, 1'b0);
        write_registers_cmd(16'h0000, 16, 1'b1);
        write_enable_cmd();
        sfw_host_i.xfer({32'h0, OP_WRITE_DIS}, 8);
        sfw_host_i.xfer({16'h0, OP_WRITE_REGS, 16'h0000}, 24);
        check("write after disable", 32'h0, {31'h0, write_in_progress});
        sfw_host_i.xfer({16'h0, OP_WRITE_REGS, 16'h0000}, 24);
        check("write without latch", 32'h0, {31'h0, write_in_progress});
        status();
        check("status after update", 32'h0, {24'h0, rd[7:0]});
    endtask : t_len

    task automatic t_lock();
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clk);
            wp_n = steps[i][17];
            write_registers_cmd(steps[i][16:1], 24, steps[i][0]);
        end
    endtask : t_lock

    task automatic t_fail();
        @(negedge clk);
        reg_update_fail = 1'b1;
        write_enable_cmd();
        sfw_host_i.xfer({16'h0, OP_WRITE_REGS, 16'h0000}, 24);
        status();
        check("status while busy", 32'h1, {31'h0, rd[0]});
        wait_idle();
        reg_update_fail = 1'b0;
        sfw_host_i.xfer({24'h0, OP_BANK_WRITE, 8'h02}, 16);
        status();
        check("fail flag", 32'h2, {30'h0, rd[6], rd[0]});
        sfw_host_i.xfer({32'h0, OP_CLEAR_STATUS}, 8);
        status();
        check("flag cleared", 32'h0, {30'h0, rd[6], rd[0]});
    endtask : t_fail

    task automatic t_array();
        int         n0;
        logic [7:0] ops [4] = '{OP_PAGE_PROG, OP_QUAD_PROG, OP_SECTOR_ERASE, OP_BULK_ERASE};
        int         bits [4] = '{40, 40, 32, 8};
        write_registers_cmd(16'h1c00, 24, 1'b1);
        n0 = n_ops;
        write_enable_cmd();
        sfw_host_i.xfer({OP_PAGE_PROG, 24'h123456, 8'haa}, 40);
        check("protected program", n0, n_ops);
        write_registers_cmd(16'h0000, 24, 1'b1);
        sfw_host_i.xfer({OP_PAGE_PROG, 24'h123456, 8'haa}, 40);
        check("program without latch", n0, n_ops);
        for (int i = 0; i < 4; i++)
        begin
            write_enable_cmd();
            sfw_host_i.xfer({ops[i], 24'h123456, 8'haa} >> (40 - bits[i]), bits[i]);
            check("op count", n0 + i + 1, n_ops);
            check("op kind", i, {30'h0, array_op_kind});
            if (i < 3)
                check("op address", 32'h02123456, array_op_addr);
        end
        sfw_host_i.xfer({24'h0, OP_BANK_WRITE, 8'h80}, 16);
        write_enable_cmd();
        sfw_host_i.xfer({OP_SECTOR_ERASE, 32'h00654321}, 40);
        check("op count 4-byte", n0 + 5, n_ops);
        check("op address 4-byte", 32'h00654321, array_op_addr);
    endtask : t_array

    initial
    begin
        resetn = 1'b0;
        wp_n = 1'b1;
        reg_update_fail = 1'b0;
        steps = '{18'h30001, 18'h00000, 18'h20001, 18'h10001,
                  18'h00000, 18'h30005, 18'h00005, 18'h20001};
        repeat (10) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(posedge clk);
        t_bank();
        t_legacy();
        t_len();
        t_lock();
        t_fail();
        t_array();
        final_report();
    end
endmodule : spi_flash_register_write_protect_test
